// >>> logic/sril_loader.sv
// Function
// - absent ROM: skip load, clear cache valids
// - skipped load: first fetch misses cache
// - present ROM: load and drive output enable
// - serial clock period is 126 cycles
// - one data bit taken per serial clock
// - load writes every bit of every block
// - load runs unattended, lowest to highest address
// - access interval may vary one system cycle
// - shift 200 bits, then write in parallel
// - tag bit 42 first, history bit 0 last
// - data and predecode bits interleaved in path
// - after load pins become software parallel I/O
// - cache flushed before load in any case
// - reset flushes second-level cache, leaves it enabled
// - first fetch at address 0, cacheable, probes L2
// - reset disables data cache without flushing
// - reset disables backup cache
// - bus unit starts from configuration reset values
// - write to flush control flushes cache
// - size field powers up at 1MB encoding
// - size 1,2,4 picks victim set 0,1,2 while backup cache is disabled
// - internal reset held through self-test
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module sril_loader
  import sril_pkg::*;
#(
  parameter int          ICACHE_LINES = 256,
  parameter logic [31:0] BIU_RESET    = 32'h0000_0000
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 rom_present_n,
  input  wire logic                 rom_data,
  output logic                      rom_oe_n,
  output logic                      rom_clk,
  input  wire logic                 selftest_done,
  input  wire sril_pkg::sril_req_t  bus_req,
  output logic [31:0]               bus_rdata,
  output logic                      ic_wr_en,
  output logic [sril_pkg::IDX_W-1:0] ic_wr_addr,
  output sril_pkg::sril_line_t      ic_wr_line,
  output logic                      ic_invalidate,
  output logic                      scache_flush,
  output logic                      scache_enable,
  output logic                      dcache_enable,
  output logic                      bcache_enable,
  output logic [1:0]                victim_set,
  output logic                      victim_set_valid,
  output logic [31:0]               biu_config,
  output logic                      cpu_reset_n,
  output logic                      fetch_start,
  output logic [39:0]               fetch_addr,
  output logic                      fetch_cacheable
);
  import sril_pkg::*;

  typedef struct packed {
    sril_phase_t      phase;
    logic [2:0]       dsync;
    logic [2:0]       psync;
    logic             data_f;
    logic             pres_n_f;
    logic [6:0]       cnt;
    logic [7:0]       bitcnt;
    logic [IDX_W-1:0] line;
    logic [SCAN_BITS-1:0] path;
    logic             rom_oe_n;
    logic             rom_clk;
    logic             ic_wr_en;
    logic [IDX_W-1:0] ic_wr_addr;
    sril_line_t       ic_wr_line;
    logic             ic_inval;
    logic             sc_flush;
    logic             cpu_rst_n;
    logic             fetch_start;
    logic [39:0]      fetch_addr;
    logic             fetch_cach;
    logic             load_done;
    logic [31:0]      rdata;
    logic [31:0]      bccfg;
    logic [4:0]       ctrl;
    logic [31:0]      biucfg;
    logic [2:0]       vsel;
  } sril_st_t;

  logic [1:0] rst_q;
  logic       rst_n;
  sril_st_t   st;
  sril_st_t   next_st;
  logic [2:0] next_vsel;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_comb begin
    next_st             = st;
    next_vsel           = 3'h0;
    next_st.ic_wr_en    = 1'b0;
    next_st.ic_inval    = 1'b0;
    next_st.sc_flush    = 1'b0;
    next_st.fetch_start = 1'b0;

    // first stage feeds only the second; a change counts once stages 2 and 3 agree
    next_st.dsync = {st.dsync[1:0], rom_data};
    next_st.psync = {st.psync[1:0], rom_present_n};
    if (st.dsync[1] == st.dsync[2]) begin
      next_st.data_f = st.dsync[2];
    end
    if (st.psync[1] == st.psync[2]) begin
      next_st.pres_n_f = st.psync[2];
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_BCCFG:  next_st.rdata = st.bccfg;
        OFS_CTRL:   next_st.rdata = {27'h0, st.ctrl};
        OFS_BIUCFG: next_st.rdata = st.biucfg;
        OFS_STATUS: begin
          next_st.rdata = 32'h0;
          next_st.rdata[STS_IDX_LSB +: IDX_W] = st.line;
          next_st.rdata[3:0] = {st.data_f, ~st.pres_n_f, st.phase == S_LOAD, st.load_done};
        end
        default:    next_st.rdata = 32'h0;
      endcase
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_ICFLUSH: next_st.ic_inval = 1'b1;
        OFS_BCCFG:   next_st.bccfg    = bus_req.wdata;
        OFS_CTRL:    next_st.ctrl     = bus_req.wdata[4:0];
        OFS_BIUCFG:  next_st.biucfg   = bus_req.wdata;
        default:     next_st.rdata    = st.rdata;
      endcase
    end

    // victim steering only means something while no backup cache is in use
    if (!st.ctrl[CTRL_BC_EN]) begin
      next_vsel = sril_victim(st.bccfg[BCSIZE_LSB +: 3]);
    end
    next_st.vsel = next_vsel;

    case (st.phase)
      S_SELFTEST: begin
        // core stays in reset until the cache self-test reports completion
        if (selftest_done) begin
          next_st.phase = S_FLUSH;
        end
      end
      S_FLUSH: begin
        next_st.ic_inval = 1'b1;
        next_st.sc_flush = 1'b1;
        next_st.cnt      = 7'h00;
        next_st.phase    = S_SAMPLE;
      end
      S_SAMPLE: begin
        // wait for the presence filter to settle before trusting it
        next_st.cnt = st.cnt + 7'h01;
        if (st.cnt == 7'(SETTLE)) begin
          next_st.cnt = 7'h00;
          if (st.pres_n_f) begin
            next_st.ic_inval    = 1'b1;
            next_st.phase       = S_DONE;
            next_st.cpu_rst_n   = 1'b1;
            next_st.fetch_start = 1'b1;
          end else begin
            next_st.rom_oe_n = 1'b0;
            next_st.bitcnt   = 8'h00;
            next_st.line     = '0;
            next_st.phase    = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        // exact 126-cycle period; the ROM must absorb the one-cycle slip of resync
        next_st.cnt = (st.cnt == 7'(SER_PERIOD - 1)) ? 7'h00 : st.cnt + 7'h01;
        next_st.rom_clk = (next_st.cnt >= 7'(SER_HALF));
        if (st.cnt == 7'(SER_SAMPLE)) begin
          next_st.path = {st.path[SCAN_BITS-2:0], st.data_f};
          if (st.bitcnt == 8'(SCAN_BITS - 1)) begin
            next_st.bitcnt     = 8'h00;
            next_st.ic_wr_en   = 1'b1;
            next_st.ic_wr_addr = st.line;
            next_st.ic_wr_line = sril_unpack(next_st.path);
            next_st.line       = st.line + IDX_W'(1);
            if (st.line == IDX_W'(ICACHE_LINES - 1)) begin
              next_st.rom_oe_n    = 1'b1;
              next_st.rom_clk     = 1'b0;
              next_st.load_done   = 1'b1;
              next_st.phase       = S_DONE;
              next_st.cpu_rst_n   = 1'b1;
              next_st.fetch_start = 1'b1;
            end
          end else begin
            next_st.bitcnt = st.bitcnt + 8'h01;
          end
        end
      end
      S_DONE: begin
        // pins are plain software outputs from here on
        next_st.rom_oe_n = ~st.ctrl[CTRL_PIN_OE];
        next_st.rom_clk  = st.ctrl[CTRL_PIN_CK];
      end
      default: begin
        next_st.phase = S_SELFTEST;
      end
    endcase

    if (next_st.fetch_start) begin
      next_st.fetch_addr = FIRST_FETCH;
      next_st.fetch_cach = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.phase    <= S_SELFTEST;
      st.pres_n_f <= 1'b1;
      st.psync    <= 3'h7;
      st.rom_oe_n <= 1'b1;
      st.bccfg    <= BCCFG_RESET;
      st.ctrl     <= CTRL_RESET;
      st.biucfg   <= BIU_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rom_oe_n         = st.rom_oe_n;
  assign rom_clk          = st.rom_clk;
  assign bus_rdata        = st.rdata;
  assign ic_wr_en         = st.ic_wr_en;
  assign ic_wr_addr       = st.ic_wr_addr;
  assign ic_wr_line       = st.ic_wr_line;
  assign ic_invalidate    = st.ic_inval;
  assign scache_flush     = st.sc_flush;
  assign scache_enable    = st.ctrl[CTRL_SC_EN];
  assign dcache_enable    = st.ctrl[CTRL_DC_EN];
  assign bcache_enable    = st.ctrl[CTRL_BC_EN];
  assign victim_set       = st.vsel[1:0];
  assign victim_set_valid = st.vsel[2];
  assign biu_config       = st.biucfg;
  assign cpu_reset_n      = st.cpu_rst_n;
  assign fetch_start      = st.fetch_start;
  assign fetch_addr       = st.fetch_addr;
  assign fetch_cacheable  = st.fetch_cach;

  // helper state read only by the checks below
  logic [7:0] gap;
  logic       seen_rise;
  logic       first_bit;
  logic       rclk_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap       <= 8'h00;
      seen_rise <= 1'b0;
      first_bit <= 1'b0;
      rclk_q    <= 1'b0;
    end else begin
      rclk_q <= st.rom_clk;
      gap <= (st.rom_clk && !rclk_q) ? 8'h01 : gap + 8'h01;
      if (st.rom_clk && !rclk_q) begin
        seen_rise <= (st.phase == S_LOAD);
      end
      if (st.phase == S_LOAD && st.cnt == 7'(SER_SAMPLE) && st.bitcnt == 8'h00) begin
        first_bit <= st.data_f;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_strobe;
    st.phase == S_LOAD && st.cnt == 7'(SER_SAMPLE);
  endsequence
  sequence s_decide;
    st.phase == S_SAMPLE && st.cnt == 7'(SETTLE);
  endsequence

  property p_skip;
    s_decide and st.pres_n_f |=> ic_invalidate && rom_oe_n && cpu_reset_n && fetch_start;
  endproperty
  a_skip: assert property (p_skip) else $error("skip path wrong");

  property p_oe_load;
    st.phase == S_LOAD |-> !rom_oe_n;
  endproperty
  a_oe_load: assert property (p_oe_load) else $error("oe not driven in load");

  property p_period;
    $rose(rom_clk) && seen_rise && st.phase == S_LOAD |-> gap == 8'(SER_PERIOD);
  endproperty
  a_period: assert property (p_period) else $error("serial clock period wrong");

  property p_bit_clk;
    s_strobe and st.bitcnt != 8'(SCAN_BITS - 1) |=> $rose(rom_clk);
  endproperty
  a_bit_clk: assert property (p_bit_clk) else $error("bit not paired with clock");

  property p_write_200;
    ic_wr_en |-> $past(st.bitcnt) == 8'(SCAN_BITS - 1) && $past(st.cnt) == 7'(SER_SAMPLE);
  endproperty
  a_write_200: assert property (p_write_200) else $error("write not after bit 200");

  property p_order;
    ic_wr_en |-> ic_wr_line.tag[29] == first_bit
      && ic_wr_line.branch_history_bits[0] == $past(st.data_f);
  endproperty
  a_order: assert property (p_order) else $error("scan order wrong");

  property p_advance;
    ic_wr_en && st.phase == S_LOAD |-> st.line == ic_wr_addr + IDX_W'(1);
  endproperty
  a_advance: assert property (p_advance) else $error("address not advanced");

  property p_last;
    ic_wr_en && ic_wr_addr == IDX_W'(ICACHE_LINES - 1) |-> rom_oe_n && cpu_reset_n ##1 !rom_clk;
  endproperty
  a_last: assert property (p_last) else $error("load did not end");

  property p_flush_first;
    st.phase == S_FLUSH |=> ic_invalidate && scache_flush && st.phase == S_SAMPLE;
  endproperty
  a_flush_first: assert property (p_flush_first) else $error("flush missing");

  property p_fetch;
    fetch_start |-> fetch_addr == FIRST_FETCH && fetch_cacheable && cpu_reset_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("first fetch wrong");

  property p_icflush;
    bus_req.wr && bus_req.addr == OFS_ICFLUSH |=> ic_invalidate;
  endproperty
  a_icflush: assert property (p_icflush) else $error("flush write ignored");

  property p_sc_enable;
    st.phase == S_FLUSH |=> scache_flush && scache_enable;
  endproperty
  a_sc_enable: assert property (p_sc_enable) else $error("scache not enabled");

  property p_caches_off;
    !cpu_reset_n |-> !dcache_enable && !bcache_enable;
  endproperty
  a_caches_off: assert property (p_caches_off) else $error("cache on in reset");

  property p_size_reset;
    st.phase == S_SELFTEST |-> st.bccfg == BCCFG_RESET;
  endproperty
  a_size_reset: assert property (p_size_reset) else $error("size field not reset");

  property p_hold_selftest;
    st.phase == S_SELFTEST && !selftest_done |=> !cpu_reset_n && st.phase == S_SELFTEST;
  endproperty
  a_hold_selftest: assert property (p_hold_selftest) else $error("early release");

  property p_pins;
    st.phase == S_DONE |=> rom_oe_n == !$past(st.ctrl[CTRL_PIN_OE])
      && rom_clk == $past(st.ctrl[CTRL_PIN_CK]);
  endproperty
  a_pins: assert property (p_pins) else $error("pins not under software");

  property p_interleave;
    ic_wr_en |-> ic_wr_line.data[127] == st.path[8] && ic_wr_line.data[95] == st.path[9]
      && ic_wr_line.data[63] == st.path[94] && ic_wr_line.data[31] == st.path[95]
      && ic_wr_line.data[0] == st.path[157]
      && ic_wr_line.data_par == {st.path[82], st.path[83]};
  endproperty
  a_interleave: assert property (p_interleave) else $error("data interleave wrong");

  property p_tag_order;
    ic_wr_en |-> ic_wr_line.tag_par == st.path[158] && ic_wr_line.valid[0] == st.path[159]
      && ic_wr_line.address_space_number[0] == st.path[162]
      && ic_wr_line.address_space_match == st.path[169] && ic_wr_line.tag[0] == st.path[170];
  endproperty
  a_tag_order: assert property (p_tag_order) else $error("tag field order wrong");

endmodule

// >>> logic/sril_pkg.sv
package sril_pkg;

  localparam int SCAN_BITS  = 200;
  localparam int SER_PERIOD = 126;
  localparam int SER_HALF   = SER_PERIOD / 2;
  localparam int SER_SAMPLE = SER_HALF - 1;
  localparam int SETTLE     = 7;
  localparam int IDX_W      = 8;

  localparam logic [7:0]  OFS_ICFLUSH = 8'h00;
  localparam logic [7:0]  OFS_BCCFG   = 8'h04;
  localparam logic [7:0]  OFS_CTRL    = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_BIUCFG  = 8'h10;

  localparam logic [31:0] BCCFG_RESET = 32'h0001_7441;
  localparam int          BCSIZE_LSB  = 4;
  localparam int          CTRL_DC_EN  = 0;
  localparam int          CTRL_BC_EN  = 1;
  localparam int          CTRL_SC_EN  = 2;
  localparam int          CTRL_PIN_OE = 3;
  localparam int          CTRL_PIN_CK = 4;
  localparam logic [4:0]  CTRL_RESET  = 5'h04;
  localparam int          STS_IDX_LSB = 8;
  localparam logic [39:0] FIRST_FETCH = 40'h00_0000_0000;

  typedef enum logic [4:0] {
    S_SELFTEST = 5'h01,
    S_FLUSH    = 5'h02,
    S_SAMPLE   = 5'h04,
    S_LOAD     = 5'h08,
    S_DONE     = 5'h10
  } sril_phase_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sril_req_t;

  // one cache location as written in parallel; tag holds bits 42..13
  typedef struct packed {
    logic [29:0]  tag;
    logic         address_space_match;
    logic [6:0]   address_space_number;
    logic         phys;
    logic [1:0]   valid;
    logic         tag_par;
    logic [127:0] data;
    logic [1:0]   data_par;
    logic [9:0]   pre_hi;
    logic [9:0]   pre_lo;
    logic [7:0]   branch_history_bits;
  } sril_line_t;

  // p[0] is the last bit shifted in, p[199] the first
  function automatic sril_line_t sril_unpack(input logic [SCAN_BITS-1:0] p);
    sril_line_t l;
    l = '0;
    for (int k = 0; k < 32; k++) begin
      l.data[127-k] = p[8+2*k];
      l.data[95-k]  = p[9+2*k];
      l.data[63-k]  = p[94+2*k];
      l.data[31-k]  = p[95+2*k];
    end
    l.branch_history_bits  = p[7:0];
    l.pre_hi               = p[81:72];
    l.data_par             = {p[82], p[83]};
    l.pre_lo               = p[93:84];
    l.tag_par              = p[158];
    l.valid                = p[160:159];
    l.phys                 = p[161];
    l.address_space_number = p[168:162];
    l.address_space_match  = p[169];
    l.tag                  = p[199:170];
    return l;
  endfunction

  // {valid, set} of the victim set picked by the backup cache size field
  function automatic logic [2:0] sril_victim(input logic [2:0] size);
    case (size)
      3'h1:    sril_victim = 3'h4;
      3'h2:    sril_victim = 3'h5;
      3'h4:    sril_victim = 3'h6;
      default: sril_victim = 3'h0;
    endcase
  endfunction

endpackage

// >>> verif/sril_rom.sv
`timescale 1ns/1ps
// serial image source; one bit per rising serial clock while enabled
module sril_rom #(
  parameter int NBITS = 400
) (
  input  wire logic rom_oe_n,
  input  wire logic rom_clk,
  output logic      rom_data
);
  logic img [NBITS];
  int   idx = 0;
  // next bit is presented at once, so any access interval is tolerated
  always @(posedge rom_clk) begin
    if (!rom_oe_n && idx < NBITS - 1) idx <= idx + 1;
  end
  // a released line shows the inverse so a stale bit never passes for data
  assign rom_data = rom_oe_n ? ~img[idx] : img[idx];
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  import sril_pkg::*;
  // two lines keep the full load near 50k cycles
  localparam int LINES = 2;
  logic                 clk_sys, nrst, rom_present_n, rom_data, selftest_done;
  logic                 rom_oe_n, rom_clk, ic_wr_en, ic_invalidate, scache_flush;
  logic                 scache_enable, dcache_enable, bcache_enable, victim_set_valid;
  logic                 cpu_reset_n, fetch_start, fetch_cacheable, rclk_d;
  logic [1:0]           victim_set;
  logic [31:0]          bus_rdata, biu_config, rv;
  logic [39:0]          fetch_addr;
  logic [IDX_W-1:0]     ic_wr_addr;
  sril_line_t           ic_wr_line;
  sril_req_t            bus_req;
  int                   error_cnt = 0, total_checks = 0, cyc = 0, last_rise = 0, n;
  int                   inv_cnt = 0, flush_cnt = 0, fs_cnt = 0, oe_low = 0;
  int                   seed = 32'hC93C7F6E;
  int                   vs [4] = '{1, 2, 4, 3};
  logic [2:0]           vx [4] = '{3'h4, 3'h5, 3'h6, 3'h0};
  logic [IDX_W-1:0]     wq_addr [$];
  sril_line_t           wq_line [$];

  sril_loader #(.ICACHE_LINES(LINES)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .rom_present_n(rom_present_n), .rom_data(rom_data),
    .rom_oe_n(rom_oe_n), .rom_clk(rom_clk), .selftest_done(selftest_done),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .ic_wr_en(ic_wr_en), .ic_wr_addr(ic_wr_addr),
    .ic_wr_line(ic_wr_line), .ic_invalidate(ic_invalidate), .scache_flush(scache_flush),
    .scache_enable(scache_enable), .dcache_enable(dcache_enable),
    .bcache_enable(bcache_enable), .victim_set(victim_set),
    .victim_set_valid(victim_set_valid), .biu_config(biu_config),
    .cpu_reset_n(cpu_reset_n), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .fetch_cacheable(fetch_cacheable));

  sril_rom #(.NBITS(200 * LINES)) rom (
    .rom_oe_n(rom_oe_n), .rom_clk(rom_clk), .rom_data(rom_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(string name, logic [199:0] exp, logic [199:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask

  // path index 0 is the last bit sent, 199 the first
  function automatic sril_line_t exp_line(int ln);
    logic [199:0] p;
    sril_line_t   e;
    for (int j = 0; j < 200; j++) p[j] = rom.img[ln * 200 + 199 - j];
    e = '0;
    for (int k = 0; k < 32; k++) begin
      e.data[127-k] = p[8+2*k];
      e.data[95-k]  = p[9+2*k];
      e.data[63-k]  = p[94+2*k];
      e.data[31-k]  = p[95+2*k];
    end
    e.branch_history_bits  = p[7:0];
    e.pre_hi               = p[81:72];
    e.data_par             = {p[82], p[83]};
    e.pre_lo               = p[93:84];
    e.tag_par              = p[158];
    e.valid                = p[160:159];
    e.phys                 = p[161];
    e.address_space_number = p[168:162];
    e.address_space_match  = p[169];
    e.tag                  = p[199:170];
    return e;
  endfunction

  always @(posedge clk_sys) begin
    cyc++;
    if (ic_wr_en === 1'b1) begin
      chk("invalidate before fill", 1, inv_cnt > 0);
      wq_addr.push_back(ic_wr_addr);
      wq_line.push_back(ic_wr_line);
    end
    inv_cnt += int'(ic_invalidate);
    flush_cnt += int'(scache_flush);
    fs_cnt += int'(fetch_start);
    if (rom_oe_n === 1'b0) oe_low = 1;
    if (rom_clk === 1'b1 && rclk_d === 1'b0 && cpu_reset_n === 1'b0) begin
      if (last_rise > 0) chk("serial period", SER_PERIOD, cyc - last_rise);
      last_rise = cyc;
    end
    rclk_d = rom_clk;
  end

  task automatic run(logic present);
    @(posedge clk_sys);
    nrst <= 1'b0;
    rom_present_n <= ~present;
    selftest_done <= 1'b0;
    repeat (16) @(posedge clk_sys);
    inv_cnt = 0;
    flush_cnt = 0;
    fs_cnt = 0;
    oe_low = 0;
    last_rise = 0;
    wq_addr.delete();
    wq_line.delete();
    chk("reset state", {6'b100100, 32'h0}, {rom_oe_n, rom_clk, cpu_reset_n, scache_enable,
        dcache_enable, bcache_enable, biu_config});
    nrst <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk("held in self test", 2'b01, {cpu_reset_n, rom_oe_n});
    selftest_done <= 1'b1;
    for (int i = 0; i < 60000 && cpu_reset_n !== 1'b1; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("first fetch", {1'b1, 40'h0, 3'b111}, {cpu_reset_n, fetch_addr, fetch_cacheable,
        scache_enable, rom_oe_n});
    chk("fetch pulses", 1, fs_cnt);
    chk("scache flushed", 1, flush_cnt > 0);
    chk("oe driven", present, oe_low);
    chk("lines written", present ? LINES : 0, wq_addr.size());
  endtask

  initial begin
    nrst = 1'b0;
    rom_present_n = 1'b0;
    selftest_done = 1'b0;
    bus_req = '0;
    rclk_d = 1'b0;
    for (int i = 0; i < 200 * LINES; i++) begin
      rv = $random(seed);
      rom.img[i] = rv[0];
    end
    run(1'b1);
    for (int i = 0; i < wq_addr.size(); i++) begin
      chk("fill address", i, wq_addr[i]);
      chk("fill line", exp_line(i), wq_line[i]);
    end
    rd(OFS_BCCFG, rv);
    chk("bccfg", BCCFG_RESET, rv);
    rd(OFS_CTRL, rv);
    chk("ctrl", CTRL_RESET, rv);
    rd(OFS_BIUCFG, rv);
    chk("biucfg", 32'h0, rv);
    rd(8'h20, rv);
    chk("unmapped", 32'h0, rv);
    n = inv_cnt;
    wr(OFS_ICFLUSH, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk("icache flush", n + 1, inv_cnt);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BCCFG, (BCCFG_RESET & ~32'h70) | (32'(vs[i]) << BCSIZE_LSB));
      repeat (2) @(posedge clk_sys);
      #1 chk("victim", vx[i], {victim_set_valid, victim_set});
    end
    wr(OFS_CTRL, 32'h1D);
    repeat (2) @(posedge clk_sys);
    #1 chk("pins after load", 4'b0110, {rom_oe_n, rom_clk, dcache_enable, bcache_enable});
    repeat (8) @(posedge clk_sys);
    rd(OFS_STATUS, rv);
    chk("pin input", {1'b1, rom_data}, {rv[0], rv[3]});
    run(1'b0);
    chk("skip invalidates", 2, inv_cnt);
    report_and_stop();
  end

  // full run is near 50.5k cycles
  initial begin
    #700000;
    error_cnt++;
    report_and_stop();
  end
endmodule
